// >>> verilog/cocm_pkg.sv
// Purpose: Shared constants and types for the clock output selector and crystal monitor.
// Assumes: AXI4-Lite register access with 32-bit data on the 40 MHz mclk.
// Notes: Every register offset, field layout, timing count and the CTRL and CFG0 reset values live here.
package cocm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CFG0_OFS = 4'h4;
  localparam logic [3:0] INT_OFS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_W = 6;
  localparam int CFG0_W = 4;
  localparam int INT_FAIL_BIT = 0;
  localparam logic [1:0] SYS_RC8M = 2'h0;
  localparam logic [1:0] SYS_XTAL = 2'h1;
  localparam logic [1:0] SYS_PLL = 2'h2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [CFG0_W-1:0] CFG0_RST = 4'h0;

  typedef struct packed {
    logic [1:0] sys_sel;
    logic pll_src_xtal;
    logic pll_en;
    logic monitor_enable;
    logic fast_crystal_osc_en;
  } cocm_ctrl_type;

  typedef struct packed {
    logic pll_half;
    logic [2:0] clock_out_select;
  } cocm_cfg0_type;

  // ----------------------------------------------------------------
  // Clock output selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OUT_NONE = 3'h0;
  localparam logic [2:0] OUT_RC28M = 3'h1;
  localparam logic [2:0] OUT_RC40K = 3'h2;
  localparam logic [2:0] OUT_SLOW_XTAL = 3'h3;
  localparam logic [2:0] OUT_SYS = 3'h4;
  localparam logic [2:0] OUT_RC8M = 3'h5;
  localparam logic [2:0] OUT_FAST_XTAL = 3'h6;
  localparam logic [2:0] OUT_PLL = 3'h7;

  // ----------------------------------------------------------------
  // Monitor timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 25;
  localparam int MON_TIMEOUT_NS = 1000;
  localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MON_OFF = 3'b001,
    MON_WATCH = 3'b010,
    MON_TRIP = 3'b100
  } cocm_mon_state_type;

endpackage

// >>> verilog/cocm_top.sv
// Purpose: Clock output selector and fast crystal failure monitor with AXI4-Lite registers.
// Assumes: mclk comes from an internal RC source independent of the fast crystal.
// Notes: Clock muxing is plain combinational selection; glitches on select changes are accepted.
// Operation
// - Three-bit code picks the clock output source.
// - Monitor runs only while monitor enable set.
// - Failure switches the fast crystal oscillator off.
// - Failure sets the sticky monitor fail flag.
// - Fail flag drives the non-maskable interrupt line.
// - Crystal-fed system clock falls back to RC8M.
// - Crystal-referenced PLL is disabled on failure.
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

module cocm_top #(
  parameter int MON_TIMEOUT_CYC = cocm_pkg::MON_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [cocm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cocm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc28m_clock,
  input wire logic rc40k_clock,
  input wire logic slow_crystal_clock,
  input wire logic rc8m_clock,
  input wire logic fast_crystal_clock,
  input wire logic pll_output_clock,
  input wire logic pll_half_clock,
  output logic system_clock_source,
  output logic [1:0] system_clock_select,
  output logic fast_crystal_osc_en,
  output logic pll_enable,
  output logic pll_src_xtal,
  output logic clock_out,
  output logic monitor_nmi
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [1:0] cocm_decode(input logic [cocm_pkg::ADDR_W-1:0] addr);
    logic [cocm_pkg::ADDR_W-1:0] word;
    word = {addr[cocm_pkg::ADDR_W-1:2], 2'h0};
    if (word == cocm_pkg::CTRL_OFS) begin
      cocm_decode = 2'h1;
    end else if (word == cocm_pkg::CFG0_OFS) begin
      cocm_decode = 2'h2;
    end else if (word == cocm_pkg::INT_OFS) begin
      cocm_decode = 2'h3;
    end else begin
      cocm_decode = 2'h0;
    end
  endfunction

  localparam int CNT_W = $clog2(MON_TIMEOUT_CYC + 1);

  cocm_pkg::cocm_ctrl_type ctrl_ff, nxt_ctrl;
  cocm_pkg::cocm_cfg0_type cfg0_ff, nxt_cfg0;
  cocm_pkg::cocm_mon_state_type mon_state_ff, nxt_mon_state;
  logic fail_flag_ff, nxt_fail_flag;
  logic [CNT_W-1:0] mon_cnt_ff, nxt_mon_cnt;
  logic xtal_s1_ff, xtal_s2_ff, xtal_s3_ff;
  logic aw_held_ff, w_held_ff;
  logic [cocm_pkg::ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic w_strb0_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  wire wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [1:0] wr_reg = cocm_decode(aw_addr_ff);
  wire [1:0] rd_reg = cocm_decode(s_axi_araddr);
  wire rd_go = s_axi_arvalid && !rvalid_ff;
  wire wr_ctrl = wr_go && (wr_reg == 2'h1) && w_strb0_ff;
  wire wr_cfg0 = wr_go && (wr_reg == 2'h2) && w_strb0_ff;
  wire clr_flag = wr_go && (wr_reg == 2'h3) && w_strb0_ff && w_data_ff[cocm_pkg::INT_FAIL_BIT];

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  wire [31:0] rd_word = (rd_reg == 2'h1) ? {26'h0, ctrl_ff} :
                        (rd_reg == 2'h2) ? {28'h0, cfg0_ff} :
                        (rd_reg == 2'h3) ? {31'h0, fail_flag_ff} : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h00000000;
      w_strb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= cocm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_reg == 2'h0) ? cocm_pkg::RESP_SLVERR : cocm_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= cocm_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (rd_reg == 2'h0) ? cocm_pkg::RESP_SLVERR : cocm_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Crystal monitor
  // ----------------------------------------------------------------
  // Edges are seen by sampling; a crystal near or above half of mclk may alias, so the
  // timeout only catches a crystal that has stopped, not one running off frequency.
  wire xtal_edge = xtal_s2_ff ^ xtal_s3_ff;
  wire mon_active = ctrl_ff.monitor_enable && ctrl_ff.fast_crystal_osc_en;
  wire mon_expired = mon_cnt_ff == CNT_W'(MON_TIMEOUT_CYC - 1);
  wire fail_pulse = (mon_state_ff == cocm_pkg::MON_WATCH) && mon_active && !xtal_edge && mon_expired;

  always_comb begin
    nxt_mon_state = mon_state_ff;
    nxt_mon_cnt = mon_cnt_ff;
    case (mon_state_ff)
      cocm_pkg::MON_OFF: begin
        nxt_mon_cnt = '0;
        if (mon_active) begin
          nxt_mon_state = cocm_pkg::MON_WATCH;
        end
      end
      cocm_pkg::MON_WATCH: begin
        if (!mon_active) begin
          nxt_mon_state = cocm_pkg::MON_OFF;
        end else if (xtal_edge) begin
          nxt_mon_cnt = '0;
        end else if (mon_expired) begin
          nxt_mon_state = cocm_pkg::MON_TRIP;
        end else begin
          nxt_mon_cnt = mon_cnt_ff + CNT_W'(1);
        end
      end
      cocm_pkg::MON_TRIP: begin
        nxt_mon_state = cocm_pkg::MON_OFF;
      end
      default: begin
        nxt_mon_state = cocm_pkg::MON_OFF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control registers and failure response
  // ----------------------------------------------------------------
  // The failure response overrides a software write in the same cycle, so software can
  // never re-enable a dead crystal by racing the monitor.
  always_comb begin
    nxt_ctrl = wr_ctrl ? cocm_pkg::cocm_ctrl_type'(w_data_ff[cocm_pkg::CTRL_W-1:0]) : ctrl_ff;
    nxt_cfg0 = wr_cfg0 ? cocm_pkg::cocm_cfg0_type'(w_data_ff[cocm_pkg::CFG0_W-1:0]) : cfg0_ff;
    if (fail_pulse) begin
      nxt_ctrl.fast_crystal_osc_en = 1'b0;
      if (ctrl_ff.sys_sel == cocm_pkg::SYS_XTAL ||
          (ctrl_ff.sys_sel == cocm_pkg::SYS_PLL && ctrl_ff.pll_src_xtal)) begin
        nxt_ctrl.sys_sel = cocm_pkg::SYS_RC8M;
      end
      if (ctrl_ff.pll_src_xtal) begin
        nxt_ctrl.pll_en = 1'b0;
      end
    end
  end

  assign nxt_fail_flag = fail_pulse || (fail_flag_ff && !clr_flag);

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff <= cocm_pkg::cocm_ctrl_type'(cocm_pkg::CTRL_RST);
      cfg0_ff <= cocm_pkg::cocm_cfg0_type'(cocm_pkg::CFG0_RST);
      fail_flag_ff <= 1'b0;
      mon_state_ff <= cocm_pkg::MON_OFF;
      mon_cnt_ff <= '0;
      xtal_s1_ff <= 1'b0;
      xtal_s2_ff <= 1'b0;
      xtal_s3_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cfg0_ff <= nxt_cfg0;
      fail_flag_ff <= nxt_fail_flag;
      mon_state_ff <= nxt_mon_state;
      mon_cnt_ff <= nxt_mon_cnt;
      xtal_s1_ff <= fast_crystal_clock;
      xtal_s2_ff <= xtal_s1_ff;
      xtal_s3_ff <= xtal_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Clock selection outputs
  // ----------------------------------------------------------------
  wire pll_pick = cfg0_ff.pll_half ? pll_half_clock : pll_output_clock;
  wire [7:0] out_src = {pll_pick, fast_crystal_clock, rc8m_clock, system_clock_source,
                        slow_crystal_clock, rc40k_clock, rc28m_clock, 1'b0};

  assign system_clock_source = (ctrl_ff.sys_sel == cocm_pkg::SYS_XTAL) ? fast_crystal_clock :
                               (ctrl_ff.sys_sel == cocm_pkg::SYS_PLL) ? pll_output_clock : rc8m_clock;
  assign clock_out = out_src[cfg0_ff.clock_out_select];
  assign system_clock_select = ctrl_ff.sys_sel;
  assign fast_crystal_osc_en = ctrl_ff.fast_crystal_osc_en;
  assign pll_enable = ctrl_ff.pll_en;
  assign pll_src_xtal = ctrl_ff.pll_src_xtal;
  assign monitor_nmi = fail_flag_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence edge_seen_s;
    xtal_edge && mon_active;
  endsequence

  sequence failure_s;
    fail_pulse;
  endsequence

  out_none_a: assert property (@(posedge mclk) disable iff (reset)
    cfg0_ff.clock_out_select == cocm_pkg::OUT_NONE |-> !clock_out)
    else $error("Clock output not idle for code zero.");

  out_rc8m_a: assert property (@(posedge mclk) disable iff (reset)
    cfg0_ff.clock_out_select == cocm_pkg::OUT_RC8M |-> clock_out == rc8m_clock)
    else $error("Clock output does not carry RC8M for code five.");

  pll_half_a: assert property (@(posedge mclk) disable iff (reset)
    cfg0_ff.clock_out_select == cocm_pkg::OUT_PLL && cfg0_ff.pll_half |-> clock_out == pll_half_clock)
    else $error("Halved PLL clock not selected.");

  mon_gate_a: assert property (@(posedge mclk) disable iff (reset)
    !ctrl_ff.monitor_enable |=> mon_state_ff != cocm_pkg::MON_WATCH ##0 !fail_pulse)
    else $error("Monitor watching while disabled.");

  edge_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    edge_seen_s |=> !fail_pulse [*7])
    else $error("Failure declared right after a crystal edge.");

  osc_off_a: assert property (@(posedge mclk) disable iff (reset)
    failure_s |=> !fast_crystal_osc_en ##1 mon_state_ff == cocm_pkg::MON_OFF)
    else $error("Crystal oscillator left on after failure.");

  flag_nmi_a: assert property (@(posedge mclk) disable iff (reset)
    failure_s |=> fail_flag_ff && monitor_nmi)
    else $error("Fail flag or NMI not raised after failure.");

  nmi_follow_a: assert property (@(posedge mclk) disable iff (reset)
    monitor_nmi == fail_flag_ff && (!$rose(monitor_nmi) || $past(fail_pulse)))
    else $error("NMI not tied to the fail flag.");

  sys_fallback_a: assert property (@(posedge mclk) disable iff (reset)
    (failure_s and ctrl_ff.sys_sel == cocm_pkg::SYS_XTAL) |=> system_clock_select == cocm_pkg::SYS_RC8M)
    else $error("System clock not moved to RC8M.");

  pll_stop_a: assert property (@(posedge mclk) disable iff (reset)
    (failure_s and ctrl_ff.pll_src_xtal) |=> !pll_enable)
    else $error("PLL still enabled after its reference failed.");

endmodule

// >>> verif/cocm_xtal_model.sv
// Purpose: Behavioural fast crystal oscillator that feeds the failure monitor.
// Assumes: The crystal oscillates only while enabled and not halted by the bench.
// Notes: A halted crystal stands still at its last level, which is what the monitor must catch.
`timescale 1ns/100ps

module cocm_xtal_model #(
  parameter int HALF_NS = 37,
  parameter int START_NS = 500
) (
  input wire logic osc_en,
  input wire logic halt,
  output logic fast_crystal_clock
);
  initial begin
    fast_crystal_clock = 1'b0;
    forever begin
      wait (osc_en && !halt);
      // Start-up delay that software must let pass before enabling the monitor.
      #START_NS;
      while (osc_en && !halt) begin
        #HALF_NS fast_crystal_clock = ~fast_crystal_clock;
      end
    end
  end
endmodule

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the clock output selector and crystal monitor.
// Assumes: Timeout shortened to 8 cycles; crystal half period 37 ns, off-grid from mclk.
// Notes: Clock outputs are sampled at the falling edge so crystal toggles never share a time step.
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

module tb_top;
  localparam int TO = 8;
  logic mclk, reset, halt;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, system_clock_select, rsp;
  logic rc28m_clock, rc40k_clock, slow_crystal_clock, rc8m_clock, fast_crystal_clock;
  logic pll_output_clock, pll_half_clock, system_clock_source, fast_crystal_osc_en;
  logic pll_enable, pll_src_xtal, clock_out, monitor_nmi;
  logic [7:0] v;
  int mismatches = 0;
  int n_tests = 0;
  int n;
  // Rows: expected source index, pll halving, selector code.
  logic [6:0] rows [9] = '{7'h00, 7'h11, 7'h22, 7'h33, 7'h44, 7'h45, 7'h56, 7'h67, 7'h7F};
  // Rows: expected pll enable, expected system select, control word.
  logic [8:0] fails [3] = '{9'h02F, 9'h117, 9'h1A7};

  cocm_top #(.MON_TIMEOUT_CYC(TO)) dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rc28m_clock, .rc40k_clock, .slow_crystal_clock, .rc8m_clock, .fast_crystal_clock,
    .pll_output_clock, .pll_half_clock, .system_clock_source, .system_clock_select,
    .fast_crystal_osc_en, .pll_enable, .pll_src_xtal, .clock_out, .monitor_nmi);

  cocm_xtal_model xtal_i (.osc_en(fast_crystal_osc_en), .halt, .fast_crystal_clock);

  // ----------------------------------------------------------------
  // Bus tasks and closing
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) mismatches++;
  endtask

  task automatic rdr(input logic [3:0] a);
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) mismatches++;
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // A hang would otherwise stall the run; the span is more than ten times the expected length.
  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    halt = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {pll_half_clock, pll_output_clock, rc8m_clock, slow_crystal_clock, rc40k_clock, rc28m_clock} = '0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rdr(4'(4 * i));
      `CHK("reg_reset", 32'h0, rd)
      `CHK("rd_resp", (i == 3) ? cocm_pkg::RESP_SLVERR : cocm_pkg::RESP_OKAY, rsp)
    end
    wr(4'hC, 32'h1, 4'hF);
    `CHK("wr_unmapped", cocm_pkg::RESP_SLVERR, rsp)
    wr(cocm_pkg::CTRL_OFS, 32'h2, 4'h0);
    rdr(cocm_pkg::CTRL_OFS);
    `CHK("ctrl_nostrb", 32'h0, rd)
    halt <= 1'b0;
    wr(cocm_pkg::CTRL_OFS, 32'h1, 4'hF);
    // The pin's alternate function lies outside this block; clock_out stands for the pin.
    foreach (rows[i]) begin
      wr(cocm_pkg::CFG0_OFS, {28'h0, rows[i][3:0]}, 4'hF);
      for (int p = 0; p < 2; p++) begin
        @(posedge mclk);
        {pll_half_clock, pll_output_clock, rc8m_clock, slow_crystal_clock, rc40k_clock, rc28m_clock} <=
          (p == 0) ? 6'h15 : 6'h2A;
        @(negedge mclk);
        v = {pll_half_clock, pll_output_clock, fast_crystal_clock, rc8m_clock, slow_crystal_clock,
             rc40k_clock, rc28m_clock, 1'b0};
        `CHK("clock_out", v[rows[i][6:4]], clock_out)
      end
    end
    halt <= 1'b1;
    foreach (fails[k]) begin
      // The crystal is quiet but the monitor is off, so no failure may be declared.
      wr(cocm_pkg::CTRL_OFS, {26'h0, fails[k][5:0] & 6'h3D}, 4'hF);
      repeat (3 * TO) @(posedge mclk);
      `CHK("nmi_disabled", 1'b0, monitor_nmi)
      halt <= 1'b0;
      repeat (30) @(posedge mclk);
      wr(cocm_pkg::CTRL_OFS, {26'h0, fails[k][5:0]}, 4'hF);
      repeat (40) @(posedge mclk);
      `CHK("nmi_running", 1'b0, monitor_nmi)
      halt <= 1'b1;
      n = 0;
      while (!monitor_nmi && n < 50) begin
        @(posedge mclk);
        n++;
      end
      `CHK("fail_delay", 1'b1, (n >= TO - 2 && n <= TO + 8))
      @(negedge mclk);
      `CHK("nmi_set", 1'b1, monitor_nmi)
      `CHK("osc_off", 1'b0, fast_crystal_osc_en)
      `CHK("sys_sel", fails[k][7:6], system_clock_select)
      `CHK("pll_en", fails[k][8], pll_enable)
      `CHK("pll_src", fails[k][3], pll_src_xtal)
      `CHK("sys_src", (fails[k][7:6] == 2'h2) ? pll_output_clock : rc8m_clock, system_clock_source)
      rdr(cocm_pkg::INT_OFS);
      `CHK("fail_flag", 32'h1, rd)
      wr(cocm_pkg::INT_OFS, 32'h1, 4'hF);
      rdr(cocm_pkg::INT_OFS);
      `CHK("flag_clear", 32'h0, rd)
      `CHK("nmi_clear", 1'b0, monitor_nmi)
      // No real-time clock selector sits in this block; software would pick a new source here.
      wr(cocm_pkg::CTRL_OFS, 32'h0, 4'hF);
    end
    wr(cocm_pkg::CTRL_OFS, 32'h24, 4'hF);
    wr(cocm_pkg::CFG0_OFS, 32'h5, 4'hF);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    `CHK("out_in_reset", 1'b0, clock_out)
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    `CHK("rst_pll", 1'b0, pll_enable)
    `CHK("rst_src", 1'b0, pll_src_xtal)
    `CHK("rst_sys", cocm_pkg::SYS_RC8M, system_clock_select)
    `CHK("rst_osc", 1'b0, fast_crystal_osc_en)
    `CHK("rst_nmi", 1'b0, monitor_nmi)
    end_of_test();
  end
endmodule
